// >>> src/pvm_pkg.sv
package pvm_pkg;

   // ----------------------------------------
   // management register indexes
   // ----------------------------------------
   localparam logic [4:0] PVM_IDX_SPECIAL_MODES = 5'h12;
   localparam logic [4:0] PVM_IDX_EXTENDED_MODE = 5'h13;
   localparam logic [4:0] PVM_IDX_ADV_ADDR_PORT = 5'h14;
   localparam logic [4:0] PVM_IDX_ADV_READ_DATA = 5'h15;

   // ----------------------------------------
   // special modes field positions
   // ----------------------------------------
   localparam int PVM_SM_RXDV_EARLY = 15;
   localparam int PVM_SM_LPBK_DIS = 14;
   localparam int PVM_SM_CRC_TX = 7;
   localparam int PVM_SM_MAC_SLOW = 6;
   localparam int PVM_SM_ADDR_HI = 4;

   // ----------------------------------------
   // extended mode field positions
   // ----------------------------------------
   localparam int PVM_EM_MODE_HI = 15;
   localparam int PVM_EM_MODE_LO = 11;
   localparam int PVM_EM_FIFO_HI = 10;
   localparam int PVM_EM_FIFO_LO = 9;
   localparam int PVM_EM_MDI01 = 2;
   localparam int PVM_EM_MDI23 = 1;
   localparam int PVM_EM_COND_PD = 0;

   // ----------------------------------------
   // advanced address port field positions
   // ----------------------------------------
   localparam int PVM_AP_READ = 15;
   localparam int PVM_AP_RSVD_HI = 14;
   localparam int PVM_AP_RSVD_LO = 7;
   localparam int PVM_AP_ADDR_HI = 6;

   // ----------------------------------------
   // reset values and counts
   // ----------------------------------------
   localparam logic [2:0] PVM_ADDR_STRAP_BASE = 3'h0;
   localparam logic [2:0] PVM_MODE_STRAP_BASE = 3'h0;
   localparam logic [2:0] PVM_FIFO_MIN_BYTES = 3'h4;
   localparam logic [1:0] PVM_STRAP_WAIT = 2'h2;
   localparam logic [6:0] PVM_ADV_LAST = 7'h0C;
   localparam logic [3:0] PVM_ADV_LAST_W = 4'hC;
   localparam int PVM_ADV_COUNT = 13;

   // ----------------------------------------
   // management frame
   // ----------------------------------------
   localparam logic [5:0] PVM_PREAMBLE_BITS = 6'h20;
   localparam logic [5:0] PVM_HDR_LAST = 6'h0B;
   localparam logic [5:0] PVM_DATA_BITS = 6'h10;
   localparam logic [5:0] PVM_DATA_LAST = 6'h0F;
   localparam logic [5:0] PVM_WTA_LAST = 6'h01;
   localparam logic [1:0] PVM_OP_READ = 2'h2;
   localparam logic [1:0] PVM_OP_WRITE = 2'h1;

   typedef enum logic [2:0] {
      PVM_SMI_PRE = 3'b000,
      PVM_SMI_ST = 3'b001,
      PVM_SMI_HDR = 3'b010,
      PVM_SMI_TA = 3'b011,
      PVM_SMI_DATA = 3'b100
   } pvm_smi_state_t;

   function automatic logic pvm_is_mapped(input logic [4:0] idx);
      pvm_is_mapped = (idx == PVM_IDX_SPECIAL_MODES) || (idx == PVM_IDX_EXTENDED_MODE) ||
                      (idx == PVM_IDX_ADV_ADDR_PORT) || (idx == PVM_IDX_ADV_READ_DATA);
   endfunction : pvm_is_mapped

endpackage : pvm_pkg

// >>> src/pvm_adv_regs.sv
`timescale 1ns/10ps
module pvm_adv_regs import pvm_pkg::*; (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [6:0] rd_addr,
   output logic [15:0] rd_data
);

   typedef struct packed {
      logic [PVM_ADV_COUNT-1:0][15:0] mem;
   } pvm_adv_state_t;

   pvm_adv_state_t q;
   pvm_adv_state_t next_q;

   // ----------------------------------------
   // advanced register set, written by the datapath
   // ----------------------------------------
   always_comb begin
      next_q = q;
      if (wr_en && (wr_addr <= PVM_ADV_LAST_W)) begin
         next_q.mem[wr_addr] = wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // addresses past the last one read zero
   assign rd_data = (rd_addr <= PVM_ADV_LAST) ? q.mem[rd_addr[3:0]] : 16'h0000;

endmodule : pvm_adv_regs

// >>> src/pvm_mode_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - special bit 15 set makes receive-valid rise early in 10 Mb reception; default off.
// - special bit 14 disables 10 Mb half-duplex loopback; kept through soft reset.
// - special bit 7 picks CRC counter source: 0 receive, 1 transmit; default 0.
// - special bit 6 reads MAC clock rate: 0 is 125MHz, 1 is 25MHz.
// - five-bit station address is our management address and scrambler seed; kept.
// - station address default comes from the two low strap pins at reset.
// - operating-mode default comes from the two upper strap pins; kept through soft reset.
// - extended bits 10:9 set transmit FIFO depth four to seven bytes; default 00.
// - extended bit 2 selects crossover for pairs 0 and 1 when automatic crossover off.
// - extended bit 1 selects crossover for pairs 2 and 3 when automatic crossover off.
// - extended bit 0 set limits parallel detect to advertised half-duplex speeds.
// - writing 1 to port bit 15 latches selected advanced register into read data.
// - port bit 15 clears itself after the latch; resets to 0.
// - seven-bit port address selects advanced register 0 to 12; resets to zero.
// - read data register at index 21 shows the latched word; resets to zero.
// - external automatic-crossover disable hands selection to the manual pair bits.
module pvm_mode_regs import pvm_pkg::*; (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [3:0] config_strap,
   input wire logic mac_clock_slow_select,
   input wire logic auto_mdix_disable,
   input wire logic adv_10hd,
   input wire logic adv_100hd,
   input wire logic adv_wr_en,
   input wire logic [3:0] adv_wr_addr,
   input wire logic [15:0] adv_wr_data,
   output logic rxdv_early_en,
   output logic loopback_10hd_dis,
   output logic crc_count_tx,
   output logic [4:0] station_address,
   output logic [4:0] operating_mode_field,
   output logic [2:0] tx_fifo_depth,
   output logic mdix_manual,
   output logic mdix_ch01,
   output logic mdix_ch23,
   output logic pd_allow_10hd,
   output logic pd_allow_100hd
);

   typedef struct packed {
      logic [1:0] mdc_sync;
      logic [1:0] mdio_sync;
      logic mdc_prev;
      logic [3:0] cfg_s1;
      logic [3:0] cfg_s2;
      logic [1:0] strap_wait;
      logic strap_done;
      pvm_smi_state_t state;
      logic [5:0] cnt;
      logic [15:0] shreg;
      logic is_read;
      logic hit;
      logic [4:0] reg_idx;
      logic mdio_out;
      logic mdio_oe;
      logic rxdv_early;
      logic lpbk_dis;
      logic crc_tx;
      logic [4:0] station_address;
      logic [4:0] operating_mode_field;
      logic [1:0] fifo_sel;
      logic mdi01;
      logic mdi23;
      logic cond_pd;
      logic [7:0] port_rsvd;
      logic [6:0] adv_addr;
      logic adv_pend;
      logic [15:0] adv_rdata;
      logic [2:0] tx_fifo_depth;
      logic mdix_manual;
      logic mdix_ch01;
      logic mdix_ch23;
      logic pd_allow_10hd;
      logic pd_allow_100hd;
   } pvm_state_t;

   pvm_state_t q;
   pvm_state_t next_q;
   logic [15:0] adv_rd_data;

   // ----------------------------------------
   // register read image
   // ----------------------------------------
   function automatic logic [15:0] pvm_read_mux(input pvm_state_t s, input logic [4:0] idx, input logic slow);
      logic [15:0] w;
      w = 16'h0000;
      case (idx)
         PVM_IDX_SPECIAL_MODES: begin
            w[PVM_SM_RXDV_EARLY] = s.rxdv_early;
            w[PVM_SM_LPBK_DIS] = s.lpbk_dis;
            w[PVM_SM_CRC_TX] = s.crc_tx;
            w[PVM_SM_MAC_SLOW] = slow;
            w[PVM_SM_ADDR_HI:0] = s.station_address;
         end
         PVM_IDX_EXTENDED_MODE: begin
            w[PVM_EM_MODE_HI:PVM_EM_MODE_LO] = s.operating_mode_field;
            w[PVM_EM_FIFO_HI:PVM_EM_FIFO_LO] = s.fifo_sel;
            w[PVM_EM_MDI01] = s.mdi01;
            w[PVM_EM_MDI23] = s.mdi23;
            w[PVM_EM_COND_PD] = s.cond_pd;
         end
         PVM_IDX_ADV_ADDR_PORT: begin
            w[PVM_AP_READ] = s.adv_pend;
            w[PVM_AP_RSVD_HI:PVM_AP_RSVD_LO] = s.port_rsvd;
            w[PVM_AP_ADDR_HI:0] = s.adv_addr;
         end
         PVM_IDX_ADV_READ_DATA: begin
            w = s.adv_rdata;
         end
         default: begin
            w = 16'h0000;
         end
      endcase
      pvm_read_mux = w;
   endfunction : pvm_read_mux

   pvm_adv_regs u_adv (
      .mclk(mclk),
      .rst_b(rst_b),
      .wr_en(adv_wr_en),
      .wr_addr(adv_wr_addr),
      .wr_data(adv_wr_data),
      .rd_addr(q.adv_addr),
      .rd_data(adv_rd_data)
   );

   always_comb begin
      logic rise;
      logic bit_in;
      logic wr;
      logic [15:0] wdata;
      logic [15:0] hdr;
      rise = q.mdc_sync[1] & ~q.mdc_prev;
      bit_in = q.mdio_sync[1];
      wr = 1'b0;
      wdata = {q.shreg[14:0], bit_in};
      hdr = {q.shreg[14:0], bit_in};
      next_q = q;

      // ----------------------------------------
      // pin synchronisers, management clock is sampled not used as a clock
      // ----------------------------------------
      next_q.mdc_sync = {q.mdc_sync[0], mdc};
      next_q.mdio_sync = {q.mdio_sync[0], mdio_in};
      next_q.mdc_prev = q.mdc_sync[1];
      next_q.cfg_s1 = config_strap;
      next_q.cfg_s2 = q.cfg_s1;

      // ----------------------------------------
      // management frame engine
      // ----------------------------------------
      if (rise) begin
         case (q.state)
            PVM_SMI_PRE: begin
               if (bit_in) begin
                  if (q.cnt != PVM_PREAMBLE_BITS) begin
                     next_q.cnt = q.cnt + 6'h01;
                  end
               end else if (q.cnt == PVM_PREAMBLE_BITS) begin
                  next_q.state = PVM_SMI_ST;
               end else begin
                  next_q.cnt = 6'h00;
               end
            end
            PVM_SMI_ST: begin
               next_q.cnt = 6'h00;
               next_q.state = bit_in ? PVM_SMI_HDR : PVM_SMI_PRE;
            end
            PVM_SMI_HDR: begin
               next_q.shreg = hdr;
               next_q.cnt = q.cnt + 6'h01;
               if (q.cnt == PVM_HDR_LAST) begin
                  next_q.cnt = 6'h00;
                  next_q.reg_idx = hdr[4:0];
                  next_q.hit = (hdr[9:5] == q.station_address) && pvm_is_mapped(hdr[4:0]);
                  next_q.is_read = (hdr[11:10] == PVM_OP_READ);
                  if ((hdr[11:10] == PVM_OP_READ) || (hdr[11:10] == PVM_OP_WRITE)) begin
                     next_q.state = PVM_SMI_TA;
                  end else begin
                     next_q.state = PVM_SMI_PRE;
                  end
               end
            end
            PVM_SMI_TA: begin
               if (q.is_read) begin
                  // word is frozen here so a latch mid-frame cannot tear it
                  next_q.shreg = pvm_read_mux(q, q.reg_idx, mac_clock_slow_select);
                  next_q.mdio_oe = q.hit;
                  next_q.mdio_out = 1'b0;
                  next_q.state = PVM_SMI_DATA;
               end else begin
                  next_q.cnt = q.cnt + 6'h01;
                  if (q.cnt == PVM_WTA_LAST) begin
                     next_q.cnt = 6'h00;
                     next_q.state = PVM_SMI_DATA;
                  end
               end
            end
            PVM_SMI_DATA: begin
               if (q.is_read) begin
                  if (q.cnt == PVM_DATA_BITS) begin
                     next_q.mdio_oe = 1'b0;
                     next_q.mdio_out = 1'b0;
                     next_q.cnt = 6'h00;
                     next_q.state = PVM_SMI_PRE;
                  end else begin
                     next_q.mdio_out = q.shreg[15];
                     next_q.shreg = {q.shreg[14:0], 1'b0};
                     next_q.cnt = q.cnt + 6'h01;
                  end
               end else begin
                  next_q.shreg = wdata;
                  next_q.cnt = q.cnt + 6'h01;
                  if (q.cnt == PVM_DATA_LAST) begin
                     wr = q.hit;
                     next_q.cnt = 6'h00;
                     next_q.state = PVM_SMI_PRE;
                  end
               end
            end
            default: begin
               next_q.cnt = 6'h00;
               next_q.mdio_oe = 1'b0;
               next_q.state = PVM_SMI_PRE;
            end
         endcase
      end

      // ----------------------------------------
      // advanced read latch, one cycle after the trigger
      // ----------------------------------------
      if (q.adv_pend) begin
         next_q.adv_rdata = adv_rd_data;
         next_q.adv_pend = 1'b0;
      end

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (wr) begin
         case (q.reg_idx)
            PVM_IDX_SPECIAL_MODES: begin
               next_q.rxdv_early = wdata[PVM_SM_RXDV_EARLY];
               next_q.lpbk_dis = wdata[PVM_SM_LPBK_DIS];
               next_q.crc_tx = wdata[PVM_SM_CRC_TX];
               next_q.station_address = wdata[PVM_SM_ADDR_HI:0];
            end
            PVM_IDX_EXTENDED_MODE: begin
               // stored as written; software is trusted to write it back unchanged
               next_q.operating_mode_field = wdata[PVM_EM_MODE_HI:PVM_EM_MODE_LO];
               next_q.fifo_sel = wdata[PVM_EM_FIFO_HI:PVM_EM_FIFO_LO];
               next_q.mdi01 = wdata[PVM_EM_MDI01];
               next_q.mdi23 = wdata[PVM_EM_MDI23];
               next_q.cond_pd = wdata[PVM_EM_COND_PD];
            end
            PVM_IDX_ADV_ADDR_PORT: begin
               next_q.port_rsvd = wdata[PVM_AP_RSVD_HI:PVM_AP_RSVD_LO];
               next_q.adv_addr = wdata[PVM_AP_ADDR_HI:0];
               if (wdata[PVM_AP_READ]) begin
                  next_q.adv_pend = 1'b1;
               end
            end
            default: begin
               next_q.adv_pend = next_q.adv_pend;
            end
         endcase
      end

      // ----------------------------------------
      // soft reset spares the kept fields
      // ----------------------------------------
      if (soft_rst) begin
         next_q.rxdv_early = 1'b0;
         next_q.crc_tx = 1'b0;
         next_q.fifo_sel = 2'h0;
         next_q.mdi01 = 1'b0;
         next_q.mdi23 = 1'b0;
         next_q.cond_pd = 1'b0;
         next_q.port_rsvd = 8'h00;
         next_q.adv_addr = 7'h00;
         next_q.adv_pend = 1'b0;
         next_q.adv_rdata = 16'h0000;
      end

      // ----------------------------------------
      // strap capture once the synchroniser has filled after release
      // ----------------------------------------
      if (!q.strap_done) begin
         if (q.strap_wait == PVM_STRAP_WAIT) begin
            next_q.station_address = {PVM_ADDR_STRAP_BASE, q.cfg_s2[1:0]};
            next_q.operating_mode_field = {PVM_MODE_STRAP_BASE, q.cfg_s2[3:2]};
            next_q.strap_done = 1'b1;
         end else begin
            next_q.strap_wait = q.strap_wait + 2'h1;
         end
      end

      // ----------------------------------------
      // registered control outputs
      // ----------------------------------------
      next_q.tx_fifo_depth = PVM_FIFO_MIN_BYTES + {1'b0, next_q.fifo_sel};
      next_q.mdix_manual = auto_mdix_disable;
      next_q.mdix_ch01 = auto_mdix_disable & next_q.mdi01;
      next_q.mdix_ch23 = auto_mdix_disable & next_q.mdi23;
      next_q.pd_allow_10hd = ~next_q.cond_pd | adv_10hd;
      next_q.pd_allow_100hd = ~next_q.cond_pd | adv_100hd;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign mdio_out = q.mdio_out;
   assign mdio_oe = q.mdio_oe;
   assign rxdv_early_en = q.rxdv_early;
   assign loopback_10hd_dis = q.lpbk_dis;
   assign crc_count_tx = q.crc_tx;
   assign station_address = q.station_address;
   assign operating_mode_field = q.operating_mode_field;
   assign tx_fifo_depth = q.tx_fifo_depth;
   assign mdix_manual = q.mdix_manual;
   assign mdix_ch01 = q.mdix_ch01;
   assign mdix_ch23 = q.mdix_ch23;
   assign pd_allow_10hd = q.pd_allow_10hd;
   assign pd_allow_100hd = q.pd_allow_100hd;

endmodule : pvm_mode_regs

// >>> verification/pvm_mode_regs_asserts.sv
`timescale 1ns/10ps
module pvm_mode_regs_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic soft_rst,
   input wire logic auto_mdix_disable,
   input wire logic adv_10hd,
   input wire logic adv_100hd,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic rxdv_early_en,
   input wire logic loopback_10hd_dis,
   input wire logic crc_count_tx,
   input wire logic [4:0] station_address,
   input wire logic [4:0] operating_mode_field,
   input wire logic [2:0] tx_fifo_depth,
   input wire logic mdix_manual,
   input wire logic mdix_ch01,
   input wire logic mdix_ch23,
   input wire logic pd_allow_10hd,
   input wire logic pd_allow_100hd
);
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // drive length counted here; a 17-bit turn is too long to unroll
   logic [7:0] oe_cnt;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         oe_cnt <= 8'h00;
      end else begin
         oe_cnt <= mdio_oe ? oe_cnt + 8'h01 : 8'h00;
      end
   end
   sequence s_soft_clear;
      ##2 (!rxdv_early_en && !crc_count_tx && tx_fifo_depth == 3'h4);
   endsequence
   sequence s_turn;
      !mdio_out ##1 mdio_oe [*8];
   endsequence
   pair_low_a: assert property (mdix_ch01 |-> $past(auto_mdix_disable))
      else $error("pair 0/1 crossover set without manual mode");
   pair_high_a: assert property (mdix_ch23 |-> $past(auto_mdix_disable))
      else $error("pair 2/3 crossover set without manual mode");
   manual_follow_a: assert property ($past(rst_b) |-> mdix_manual == $past(auto_mdix_disable))
      else $error("manual crossover flag does not follow input");
   pd_ten_a: assert property ($past(rst_b) && !pd_allow_10hd |-> !$past(adv_10hd))
      else $error("10 Mb detect refused although advertised");
   pd_hundred_a: assert property ($past(rst_b) && !pd_allow_100hd |-> !$past(adv_100hd))
      else $error("100 Mb detect refused although advertised");
   fifo_floor_a: assert property ($past(rst_b) |-> tx_fifo_depth[2])
      else $error("fifo depth below four bytes");
   soft_clear_a: assert property (soft_rst |-> s_soft_clear)
      else $error("soft reset left a volatile bit set");
   soft_keep_a: assert property (soft_rst |=> ($stable(station_address) && $stable(operating_mode_field) &&
      $stable(loopback_10hd_dis)) [*2])
      else $error("soft reset disturbed a kept field");
   turn_start_a: assert property ($rose(mdio_oe) |-> s_turn)
      else $error("read turnaround not driven low and held");
   drive_len_a: assert property ($fell(mdio_oe) |-> oe_cnt inside {[132:140]})
      else $error("read drive length wrong");
endmodule : pvm_mode_regs_chk

bind pvm_mode_regs pvm_mode_regs_chk u_chk (.mclk, .rst_b, .soft_rst, .auto_mdix_disable, .adv_10hd,
   .adv_100hd, .mdio_out, .mdio_oe, .rxdv_early_en, .loopback_10hd_dis, .crc_count_tx, .station_address,
   .operating_mode_field, .tx_fifo_depth, .mdix_manual, .mdix_ch01, .mdix_ch23, .pd_allow_10hd, .pd_allow_100hd);

// >>> verification/pvm_smi_mac.sv
`timescale 1ns/10ps
module pvm_smi_mac import pvm_pkg::*; (
   output logic mdc,
   output logic mdio_drive,
   output logic mdio_en,
   input wire logic mdio_wire,
   output logic [15:0] rd_word,
   output logic rd_done
);
   // ----------------------------------------
   // management frame master
   // ----------------------------------------
   int hp = 80;
   initial begin
      mdc = 1'b0;
      mdio_drive = 1'b1;
      mdio_en = 1'b0;
      rd_word = 16'h0000;
      rd_done = 1'b0;
   end
   // clock stands low between frames; released line shows the pull-up
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
      logic [63:0] v;
      logic [15:0] d;
      d = wd;
      if (op == PVM_OP_WRITE && ra == PVM_IDX_ADV_ADDR_PORT) d[14:7] = 8'h03;
      v = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, d};
      for (int i = 0; i < 64; i++) begin
         mdc = 1'b0;
         mdio_en = (op == PVM_OP_WRITE) || (i < 46);
         mdio_drive = v[63-i];
         #(hp);
         mdc = 1'b1;
         if (i >= 48) rd_word = {rd_word[14:0], mdio_wire};
         #(hp);
      end
      mdc = 1'b0;
      mdio_en = 1'b0;
      rd_done = (op == PVM_OP_READ);
      #(2 * hp);
      rd_done = 1'b0;
   endtask : frame
endmodule : pvm_smi_mac

// >>> verification/pvm_mode_regs_tb.sv
`timescale 1ns/10ps
module pvm_mode_regs_tb import pvm_pkg::*; ;
   logic mclk, rst_b, soft_rst, mdc, mdio_drive, mdio_en, rd_done, mdio_out, mdio_oe;
   logic mac_clock_slow_select, auto_mdix_disable, adv_10hd, adv_100hd, adv_wr_en;
   logic rxdv_early_en, loopback_10hd_dis, crc_count_tx, mdix_manual, mdix_ch01, mdix_ch23;
   logic pd_allow_10hd, pd_allow_100hd;
   logic [3:0] config_strap, adv_wr_addr;
   logic [15:0] adv_wr_data, rd_word;
   logic [4:0] station_address, operating_mode_field, pa;
   logic [2:0] tx_fifo_depth, low;
   logic [16:0] seed;
   logic [15:0] exp_q[$];
   int n_mismatch, total_checks;
   // open-drain line with pull-up
   wire logic mdio_wire = mdio_oe ? mdio_out : (mdio_en ? mdio_drive : 1'b1);

   pvm_mode_regs dut (.mclk, .rst_b, .soft_rst, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe, .config_strap,
      .mac_clock_slow_select, .auto_mdix_disable, .adv_10hd, .adv_100hd, .adv_wr_en, .adv_wr_addr, .adv_wr_data,
      .rxdv_early_en, .loopback_10hd_dis, .crc_count_tx, .station_address, .operating_mode_field, .tx_fifo_depth,
      .mdix_manual, .mdix_ch01, .mdix_ch23, .pd_allow_10hd, .pd_allow_100hd);
   pvm_smi_mac smi (.mdc, .mdio_drive, .mdio_en, .mdio_wire, .rd_word, .rd_done);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      lfsr = {s[15:0], s[16] ^ s[13]};
   endfunction : lfsr
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t pin=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pin
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      smi.frame(PVM_OP_WRITE, pa, ra, d);
   endtask : wr
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      exp_q.push_back(e);
      smi.frame(PVM_OP_READ, pa, ra, 16'hFFFF);
   endtask : rd
   task automatic adv_put(input logic [3:0] a, input logic [15:0] d);
      @(negedge mclk);
      adv_wr_en = 1'b1;
      adv_wr_addr = a;
      adv_wr_data = d;
      @(negedge mclk);
      adv_wr_en = 1'b0;
   endtask : adv_put
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   always @(posedge rd_done) begin
      chk_word(rd_word, exp_q.pop_front());
   end
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      #1500000;
      n_mismatch++;
      conclude();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst_b, soft_rst, auto_mdix_disable, adv_10hd, adv_100hd, adv_wr_en} = 6'h00;
      mac_clock_slow_select = 1'b1;
      config_strap = 4'h9;
      adv_wr_addr = 4'h0;
      adv_wr_data = 16'h0000;
      pa = 5'h01;
      seed = 17'h1132E;
      n_mismatch = 0;
      total_checks = 0;
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (6) @(negedge mclk);
      chk_pin(station_address, 5'h01);
      chk_pin(operating_mode_field, 5'h02);
      rd(PVM_IDX_SPECIAL_MODES, 16'h0041);
      rd(PVM_IDX_EXTENDED_MODE, 16'h1000);
      rd(PVM_IDX_ADV_ADDR_PORT, 16'h0000);
      rd(PVM_IDX_ADV_READ_DATA, 16'h0000);
      rd(5'h16, 16'hFFFF);
      $display("reset values done");
      wr(PVM_IDX_SPECIAL_MODES, 16'hFFE1);
      rd(PVM_IDX_SPECIAL_MODES, 16'hC0C1);
      chk_pin({2'h0, rxdv_early_en, loopback_10hd_dis, crc_count_tx}, 5'h07);
      $display("special modes done");
      for (int f = 0; f < 4; f++) begin
         seed = lfsr(seed);
         low = (f == 3) ? 3'h7 : seed[2:0];
         @(negedge mclk);
         auto_mdix_disable = f[0];
         {adv_100hd, adv_10hd} = (f == 3) ? 2'h2 : seed[4:3];
         wr(PVM_IDX_EXTENDED_MODE, {5'h02, f[1:0], 6'h3F, low});
         rd(PVM_IDX_EXTENDED_MODE, {5'h02, f[1:0], 6'h00, low});
         chk_pin({2'h0, tx_fifo_depth}, {3'h0, f[1:0]} + 5'h04);
         chk_pin({2'h0, mdix_manual, mdix_ch01, mdix_ch23}, {2'h0, f[0], f[0] & low[2], f[0] & low[1]});
         chk_pin({3'h0, pd_allow_10hd, pd_allow_100hd}, {3'h0, !low[0] | adv_10hd, !low[0] | adv_100hd});
      end
      $display("extended mode done");
      for (int a = 0; a < 14; a++) begin
         seed = lfsr(seed);
         adv_put(4'(a), seed[15:0]);
         wr(PVM_IDX_ADV_ADDR_PORT, 16'h8000 | 16'(a));
         rd(PVM_IDX_ADV_ADDR_PORT, 16'h0180 | 16'(a));
         rd(PVM_IDX_ADV_READ_DATA, (a < 13) ? seed[15:0] : 16'h0000);
      end
      wr(PVM_IDX_ADV_READ_DATA, 16'hFFFF);
      rd(PVM_IDX_ADV_READ_DATA, 16'h0000);
      $display("advanced port done");
      @(negedge mclk);
      soft_rst = 1'b1;
      mac_clock_slow_select = 1'b0;
      @(negedge mclk);
      soft_rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk_pin({2'h0, rxdv_early_en, loopback_10hd_dis, crc_count_tx}, 5'h02);
      chk_pin(station_address, 5'h01);
      chk_pin(operating_mode_field, 5'h02);
      rd(PVM_IDX_SPECIAL_MODES, 16'h4001);
      rd(PVM_IDX_EXTENDED_MODE, 16'h1000);
      rd(PVM_IDX_ADV_ADDR_PORT, 16'h0000);
      $display("soft reset done");
      smi.hp = 120;
      wr(PVM_IDX_SPECIAL_MODES, 16'h4003);
      smi.hp = 80;
      rd(PVM_IDX_SPECIAL_MODES, 16'hFFFF);
      pa = 5'h03;
      rd(PVM_IDX_SPECIAL_MODES, 16'h4003);
      chk_pin(station_address, 5'h03);
      $display("station address done");
      conclude();
   end
endmodule : pvm_mode_regs_tb
